// ---- sfp_pkg.sv ----
// package: forwarding-policy types and constants
package sfp_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // ports and tag layout
  localparam logic [1:0] PORT1 = 2'h0;
  localparam logic [1:0] PORT2 = 2'h1;
  localparam logic [1:0] PORT3 = 2'h2;
  localparam logic [2:0] MASK_P3 = 3'h4;
  localparam logic [2:0] MASK_NONE = 3'h0;
  localparam logic [1:0] TAG_LOOKUP = 2'h0;
  localparam int TAG_DST_LO = 0;
  localparam int TAG_PRI_LO = 2;
  localparam logic [10:0] TAG_LEN = 11'h001;

  ////////////////////////////////////////////////////////////////////////////
  // igmp recognition
  localparam logic [3:0] IP_VER4 = 4'h4;
  localparam logic [7:0] IP_PROTO_IGMP = 8'h02;

  ////////////////////////////////////////////////////////////////////////////
  // rate limiting, credit unit is one kbps for one clock
  localparam int CLK_HZ = 10_000_000;
  localparam logic [31:0] BYTE_UNITS = 32'(8 * (CLK_HZ / 1000));
  localparam logic [16:0] KBPS_STEP = 17'h00040;
  localparam logic [6:0] FINE_MAX_CODE = 7'h0F;
  localparam logic [16:0] MBPS_STEP = 17'h003E8;
  localparam logic [16:0] MAX_KBPS_10 = 17'h02710;
  localparam logic [16:0] MAX_KBPS_100 = 17'h186A0;
  localparam logic [10:0] IFG_BYTES = 11'h00C;
  localparam logic [10:0] PRE_BYTES = 11'h008;
  localparam logic [10:0] MIN_FRAME = 11'h040;
  localparam logic [10:0] MAX_FRAME = 11'h600;
  localparam logic signed [31:0] IG_CAP = 32'sh0753_0000;
  localparam logic signed [31:0] EG_CAP = 32'sh0000_0000;
  localparam int NQ = 12;

  typedef enum logic [1:0] {
    SFP_CLS_ALL = 2'b00,
    SFP_CLS_MC = 2'b01,
    SFP_CLS_BC = 2'b10,
    SFP_CLS_UU = 2'b11
  } sfp_class_t;

  typedef enum logic [1:0] {
    SFP_SZ_DATA = 2'b00,
    SFP_SZ_IFG = 2'b01,
    SFP_SZ_PRE = 2'b10
  } sfp_size_t;

  ////////////////////////////////////////////////////////////////////////////
  // carriers
  typedef struct packed {
    logic [1:0] src;
    logic [2:0] lookup;
    logic mcast;
    logic bcast;
    logic static_hit;
    logic [2:0] static_mbr;
    logic ip_eth;
    logic ip_snap;
    logic [3:0] ip_ver;
    logic [7:0] ip_proto;
    logic err;
    logic [1:0] prio;
    logic [7:0] tag;
    logic [10:0] len;
  } sfp_desc_t;

  typedef struct packed {
    logic [1:0] src;
    logic [2:0] dest;
    logic [1:0] prio;
    logic strip_tag;
    logic add_tag;
    logic fcs_redo;
    logic [7:0] tag;
    logic trap;
    logic mirror;
    logic drop;
    logic [10:0] len;
  } sfp_fwd_t;

  typedef struct packed {
    logic tail_en;
    logic tail_rep;
    logic snoop_en;
    logic mir_and;
    logic mir_bad;
    logic [2:0] rx_sniff;
    logic [2:0] tx_sniff;
    logic [2:0] sniffer;
    logic uu_en;
    logic [2:0] uu_mask;
    sfp_class_t ig_class;
    sfp_size_t size_mode;
    logic [2:0] speed10;
    logic fc_mode;
  } sfp_cfg_t;

  typedef struct packed {
    logic valid;
    logic [1:0] port;
    logic [1:0] queue;
    logic [10:0] len;
  } sfp_txev_t;

endpackage : sfp_pkg

// ---- sfp_skid2.sv ----
// two-entry buffer between decision stage and frame mover
`timescale 1ns/1ps
module sfp_skid2 #(
  parameter int W = $bits(sfp_pkg::sfp_fwd_t)
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);

  logic [W-1:0] spare;
  logic in_fire;
  logic load_out;

  assign in_fire = in_valid && in_ready;
  assign load_out = !out_valid || out_ready;

  ////////////////////////////////////////////////////////////////////////////
  // in_ready kept as a register so the source sees a clean level
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      out_valid <= 1'b0;
      out_data <= '0;
      spare <= '0;
      in_ready <= 1'b1;
    end else if (load_out) begin
      if (!in_ready) begin
        out_data <= spare;
        out_valid <= 1'b1;
        in_ready <= 1'b1;
      end else begin
        out_data <= in_data;
        out_valid <= in_fire;
      end
    end else if (in_fire) begin
      spare <= in_data;
      in_ready <= 1'b0;
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  AST_BUF_HOLD: assert property (
    out_valid && !out_ready |=> out_valid && $stable(out_data))
    else $error("buffered word changed while stalled");

endmodule : sfp_skid2

// ---- sfp_policy.sv ----
// forwarding-policy engine: tail tag, snooping, mirroring, rate limits
`timescale 1ns/1ps
module sfp_policy (
  input wire logic clk,
  input wire logic rst,
  input wire sfp_pkg::sfp_cfg_t cfg,
  input wire logic [sfp_pkg::NQ-1:0][6:0] ig_rate,
  input wire logic [sfp_pkg::NQ-1:0][6:0] eg_rate,
  input wire logic in_valid,
  output logic in_ready,
  input wire sfp_pkg::sfp_desc_t in_desc,
  output logic out_valid,
  input wire logic out_ready,
  output sfp_pkg::sfp_fwd_t out_fwd,
  input wire sfp_pkg::sfp_txev_t tx_ev,
  output logic [sfp_pkg::NQ-1:0] eg_hold,
  input wire logic [2:0] mem_full,
  output logic [2:0] fc_req,
  output logic [2:0] mem_drop
);

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  // rate code to kbps, zero meaning no limit
  // above the port's speed is also no limit
  function automatic logic [16:0] rate_kbps(
    input logic [6:0] code,
    input logic slow
  );
    logic [16:0] kbps;
    kbps = '0;
    if (code <= sfp_pkg::FINE_MAX_CODE) begin
      kbps = 17'(code) * sfp_pkg::KBPS_STEP;
    end else begin
      kbps = 17'(code - sfp_pkg::FINE_MAX_CODE) * sfp_pkg::MBPS_STEP;
    end
    if (slow && kbps > sfp_pkg::MAX_KBPS_10) begin
      kbps = '0;
    end
    if (kbps > sfp_pkg::MAX_KBPS_100) begin
      kbps = '0;
    end
    return kbps;
  endfunction : rate_kbps

  // bytes charged per frame, in credit units
  function automatic logic signed [31:0] frame_cost(
    input logic [10:0] len,
    input sfp_pkg::sfp_size_t mode
  );
    logic [10:0] bytes;
    bytes = len;
    case (mode)
      sfp_pkg::SFP_SZ_IFG: bytes = len + sfp_pkg::IFG_BYTES;
      sfp_pkg::SFP_SZ_PRE: bytes = len + sfp_pkg::PRE_BYTES;
      default: bytes = len;
    endcase
    return $signed(32'(bytes) * sfp_pkg::BYTE_UNITS);
  endfunction : frame_cost

  function automatic logic signed [31:0] refill(
    input logic signed [31:0] cr,
    input logic [16:0] add,
    input logic signed [31:0] cost,
    input logic signed [31:0] cap
  );
    logic signed [31:0] nc;
    nc = cr + $signed({15'h0000, add}) - cost;
    return (nc > cap) ? cap : nc;
  endfunction : refill

  ////////////////////////////////////////////////////////////////////////////
  // decision stage
  sfp_pkg::sfp_desc_t d;
  sfp_pkg::sfp_fwd_t next_fwd;
  logic fire;
  logic host;
  logic igmp;
  logic unk_uc;
  logic rx_m;
  logic tx_m;
  logic mir;
  logic cls_hit;
  logic ig_drop;
  logic [3:0] ig_idx;
  logic [16:0] ig_add;
  logic buf_ready;
  logic [2:0] src_bit;
  logic signed [31:0] ig_cr [sfp_pkg::NQ];
  logic signed [31:0] eg_cr [sfp_pkg::NQ];

  assign d = in_desc;
  assign fire = in_valid && buf_ready;
  assign in_ready = buf_ready;
  assign host = (d.src == sfp_pkg::PORT3);
  assign src_bit = 3'h1 << d.src;
  assign unk_uc = !d.mcast && !d.bcast && !d.static_hit;

  // ip over ethernet type or snap, version 4, protocol 2
  assign igmp = (d.ip_eth || d.ip_snap) && d.ip_ver == sfp_pkg::IP_VER4
    && d.ip_proto == sfp_pkg::IP_PROTO_IGMP;

  // which frame classes the ingress meter counts
  always_comb begin
    case (cfg.ig_class)
      sfp_pkg::SFP_CLS_ALL: cls_hit = 1'b1;
      sfp_pkg::SFP_CLS_MC: cls_hit = d.mcast && !d.bcast;
      sfp_pkg::SFP_CLS_BC: cls_hit = d.bcast;
      sfp_pkg::SFP_CLS_UU: cls_hit = unk_uc;
      default: cls_hit = 1'b1;
    endcase
  end

  always_comb begin
    next_fwd = '0;
    next_fwd.src = d.src;
    next_fwd.dest = d.lookup;
    next_fwd.prio = d.prio;
    // strip only while tail tagging is enabled
    next_fwd.strip_tag = cfg.tail_en && host;
    if (next_fwd.strip_tag) begin
      next_fwd.prio = d.tag[sfp_pkg::TAG_PRI_LO +: 2];
    end
    // host picks destination, code zero falls through to lookup
    if (next_fwd.strip_tag
        && d.tag[sfp_pkg::TAG_DST_LO +: 2] != sfp_pkg::TAG_LOOKUP) begin
      next_fwd.dest = {1'b0, d.tag[sfp_pkg::TAG_DST_LO +: 2]};
    end else if (d.mcast && !d.bcast && d.static_hit) begin
      next_fwd.dest = d.static_mbr;
    end else if (unk_uc && cfg.uu_en) begin
      // unknown unicast filtered or sent to chosen ports
      next_fwd.dest = cfg.uu_mask;
    end
    next_fwd.dest = next_fwd.dest & ~src_bit;
  end

  assign rx_m = cfg.rx_sniff[d.src];
  assign tx_m = |(next_fwd.dest & cfg.tx_sniff);
  assign mir = cfg.mir_and ? (rx_m && tx_m) : (rx_m || tx_m);

  // ingress meter for this frame's port and priority
  assign ig_idx = {d.src, next_fwd.prio};
  assign ig_add = rate_kbps(ig_rate[ig_idx], cfg.speed10[d.src]);
  // over the limit means the frame is dropped
  assign ig_drop = cls_hit && ig_add != '0 && ig_cr[ig_idx] < 0;

  sfp_pkg::sfp_fwd_t fin;
  always_comb begin
    fin = next_fwd;
    fin.mirror = 1'b0;
    if (mir) begin
      fin.mirror = 1'b1;
      fin.dest = fin.dest | cfg.sniffer;
    end
    // errored frames only to the sniffer, if allowed
    if (d.err) begin
      fin.mirror = cfg.mir_bad && rx_m;
      fin.dest = fin.mirror ? cfg.sniffer : sfp_pkg::MASK_NONE;
    end else if (cfg.snoop_en && igmp && !host) begin
      // trap to processor port, nothing else
      fin.trap = 1'b1;
      fin.mirror = 1'b0;
      fin.dest = sfp_pkg::MASK_P3;
    end
    if (ig_drop) begin
      fin.dest = sfp_pkg::MASK_NONE;
      fin.mirror = 1'b0;
    end
    fin.drop = (fin.dest == sfp_pkg::MASK_NONE);
    // tag only on the copy to port three
    fin.add_tag = cfg.tail_en && fin.dest[sfp_pkg::PORT3] && !host;
    // tag reports ingress port, other bits unused
    fin.tag = {7'h00, fin.add_tag && d.src == sfp_pkg::PORT2};
    // length shrinks only when the tag is stripped, fcs is rebuilt on strip or add
    fin.fcs_redo = fin.strip_tag || fin.add_tag;
    fin.len = d.len;
    if (fin.strip_tag) begin
      fin.len = d.len - sfp_pkg::TAG_LEN;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // ingress credit, a burst of two long frames is tolerated in data size mode
  // one meter per port and priority
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < sfp_pkg::NQ; i++) begin
        ig_cr[i] <= sfp_pkg::IG_CAP;
      end
    end else begin
      for (int i = 0; i < sfp_pkg::NQ; i++) begin
        logic [16:0] add;
        logic signed [31:0] cost;
        add = rate_kbps(ig_rate[i], cfg.speed10[i/4]);
        cost = '0;
        if (fire && cls_hit && !ig_drop && ig_idx == 4'(i)) begin
          cost = frame_cost(d.len, cfg.size_mode);
        end
        if (add == '0) begin
          ig_cr[i] <= sfp_pkg::IG_CAP;
        end else begin
          ig_cr[i] <= refill(ig_cr[i], add, cost, sfp_pkg::IG_CAP);
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // egress leaky bucket, capped at zero so no burst builds up
  // a queue waits until its bucket has drained
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < sfp_pkg::NQ; i++) begin
        eg_cr[i] <= sfp_pkg::EG_CAP;
      end
    end else begin
      for (int i = 0; i < sfp_pkg::NQ; i++) begin
        logic [16:0] add;
        logic signed [31:0] cost;
        add = rate_kbps(eg_rate[i], cfg.speed10[i/4]);
        cost = '0;
        if (tx_ev.valid && {tx_ev.port, tx_ev.queue} == 4'(i)) begin
          cost = frame_cost(tx_ev.len, cfg.size_mode);
        end
        if (add == '0) begin
          eg_cr[i] <= sfp_pkg::EG_CAP;
        end else begin
          eg_cr[i] <= refill(eg_cr[i], add, cost, sfp_pkg::EG_CAP);
        end
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      eg_hold <= '0;
    end else begin
      for (int i = 0; i < sfp_pkg::NQ; i++) begin
        eg_hold[i] <= eg_cr[i] < 0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // congestion response
  // full memory asks for pause or drops, one per port
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      fc_req <= '0;
      mem_drop <= '0;
    end else begin
      fc_req <= mem_full & {3{cfg.fc_mode}};
      mem_drop <= mem_full & {3{!cfg.fc_mode}};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // a stalled receiver leaves the word in the buffer
  sfp_skid2 #(
    .W($bits(sfp_pkg::sfp_fwd_t))
  ) u_buf (
    .clk(clk),
    .rst(rst),
    .in_valid(in_valid),
    .in_ready(buf_ready),
    .in_data(fin),
    .out_valid(out_valid),
    .out_ready(out_ready),
    .out_data(out_fwd)
  );

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  logic direct;
  assign direct = fire && (!out_valid || out_ready);

  AST_TAG_OFF: assert property (
    direct && !cfg.tail_en |=> !out_fwd.add_tag && !out_fwd.strip_tag)
    else $error("tail tag handled while disabled");

  AST_HOST_DEST: assert property (
    direct && cfg.tail_en && host && !d.err && !ig_drop && !mir
    && d.tag[1:0] != 2'h0 |=> out_fwd.dest == {1'b0, $past(d.tag[1:0])})
    else $error("host tag destination not honoured");

  AST_HOST_PRIO: assert property (
    direct && cfg.tail_en && host |=> out_fwd.prio == $past(d.tag[3:2]))
    else $error("host tag priority not honoured");

  AST_SRC_TAG: assert property (
    direct && fin.add_tag |=> out_fwd.tag[7:1] == 7'h00
    && out_fwd.tag[0] == ($past(d.src) == sfp_pkg::PORT2))
    else $error("egress tag does not name source port");

  AST_SNOOP: assert property (
    direct && cfg.snoop_en && igmp && !host && !d.err && !ig_drop
    |=> out_fwd.dest == 3'h4 && out_fwd.trap)
    else $error("igmp frame not trapped to processor");

  AST_MCAST: assert property (
    direct && !host && d.mcast && !d.bcast && d.static_hit && !mir
    && !d.err && !igmp && !ig_drop
    |=> out_fwd.dest == ($past(d.static_mbr) & ~$past(src_bit)))
    else $error("static multicast not trimmed");

  AST_MIR_AND: assert property (
    direct && cfg.mir_and && !d.err && !(cfg.snoop_en && igmp)
    && !ig_drop |=> out_fwd.mirror == $past(rx_m && tx_m))
    else $error("and-mode mirror mismatch");

  AST_IG_DROP: assert property (
    direct && ig_drop |=> out_fwd.drop && out_fwd.dest == 3'h0)
    else $error("over-limit frame not dropped");

  AST_EG_HOLD: assert property (
    tx_ev.valid && tx_ev.len >= sfp_pkg::MIN_FRAME
    && tx_ev.len <= sfp_pkg::MAX_FRAME
    && rate_kbps(eg_rate[{tx_ev.port, tx_ev.queue}],
      cfg.speed10[tx_ev.port]) != 17'h0 && $stable(eg_rate)
    && $stable(cfg) |-> ##2 eg_hold[{$past(tx_ev.port,2),
      $past(tx_ev.queue,2)}])
    else $error("egress queue not held after frame");

  AST_FC: assert property (
    mem_full != 3'h0 |=> (fc_req | mem_drop) == $past(mem_full))
    else $error("full memory without drop or pause");

endmodule : sfp_policy

// ---- sfp_host_sink.sv ----
// host-side consumer of forwarding decisions, with random stalls
`timescale 1ns/1ps
module sfp_host_sink (
  input wire logic clk,
  input wire logic rst,
  input wire logic [7:0] busy_pct,
  input wire logic out_valid,
  output logic out_ready
);
  initial begin
    out_ready = 1'b0;
  end
  // stall never depends on out_valid, as a slow host would behave
  always @(negedge clk) begin
    if (rst) begin
      out_ready <= 1'b0;
    end else begin
      out_ready <= (($urandom % 100) >= busy_pct);
    end
  end
endmodule : sfp_host_sink

// ---- tb.sv ----
// testbench for the forwarding-policy engine
`timescale 1ns/1ps
module tb;
  logic clk = 1'b0;
  logic rst = 1'b1;
  sfp_pkg::sfp_cfg_t cfg = '0;
  logic [sfp_pkg::NQ-1:0][6:0] ig_rate = '0;
  logic [sfp_pkg::NQ-1:0][6:0] eg_rate = '0;
  logic in_valid = 1'b0;
  logic in_ready;
  sfp_pkg::sfp_desc_t in_desc = '0;
  logic out_valid;
  logic out_ready;
  sfp_pkg::sfp_fwd_t out_fwd;
  sfp_pkg::sfp_txev_t tx_ev = '0;
  logic [sfp_pkg::NQ-1:0] eg_hold;
  logic [2:0] mem_full = 3'h0;
  logic [2:0] fc_req;
  logic [2:0] mem_drop;
  logic [7:0] busy = 8'h00;
  int failures = 0;
  int n_checks = 0;
  sfp_pkg::sfp_fwd_t exp_q[$];
  sfp_pkg::sfp_desc_t d;
  int n;

  always #50 clk = ~clk;

  sfp_policy dut (.clk(clk), .rst(rst), .cfg(cfg), .ig_rate(ig_rate),
    .eg_rate(eg_rate), .in_valid(in_valid), .in_ready(in_ready),
    .in_desc(in_desc), .out_valid(out_valid), .out_ready(out_ready),
    .out_fwd(out_fwd), .tx_ev(tx_ev), .eg_hold(eg_hold),
    .mem_full(mem_full), .fc_req(fc_req), .mem_drop(mem_drop));
  sfp_host_sink host (.clk(clk), .rst(rst), .busy_pct(busy),
    .out_valid(out_valid), .out_ready(out_ready));

  task automatic finish_test();
    $display("checks %0d, failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : finish_test

  task automatic chk(input string what, input logic [31:0] e,
                     input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      failures++;
      $display("[FAIL] %s expected %0h seen %0h", what, e, g);
    end
  endtask : chk

  ////////////////////////////////////////////////////////////////////////
  // expected decision for one descriptor
  function automatic sfp_pkg::sfp_fwd_t exp_fwd(sfp_pkg::sfp_desc_t x,
                                                sfp_pkg::sfp_cfg_t c);
    sfp_pkg::sfp_fwd_t f;
    logic host;
    logic rx;
    logic m;
    f = '0;
    host = c.tail_en && x.src == sfp_pkg::PORT3;
    f.prio = host ? x.tag[3:2] : x.prio;
    if (host && x.tag[1:0] != sfp_pkg::TAG_LOOKUP) begin
      f.dest = {1'b0, x.tag[1:0]};
    end else if (x.mcast && !x.bcast && x.static_hit) begin
      f.dest = x.static_mbr;
    end else if (!x.mcast && !x.bcast && !x.static_hit && c.uu_en) begin
      f.dest = c.uu_mask;
    end else begin
      f.dest = x.lookup;
    end
    f.dest &= ~(3'h1 << x.src);
    rx = c.rx_sniff[x.src];
    m = c.mir_and ? (rx && |(f.dest & c.tx_sniff))
                  : (rx || |(f.dest & c.tx_sniff));
    f.src = x.src;
    f.mirror = m;
    if (m) f.dest |= c.sniffer;
    if (x.err) begin
      f.mirror = c.mir_bad && rx;
      f.dest = f.mirror ? c.sniffer : 3'h0;
    end else if (c.snoop_en && x.src != sfp_pkg::PORT3 &&
        (x.ip_eth || x.ip_snap) && x.ip_ver == sfp_pkg::IP_VER4 &&
        x.ip_proto == sfp_pkg::IP_PROTO_IGMP) begin
      f.trap = 1'b1;
      f.mirror = 1'b0;
      f.dest = sfp_pkg::MASK_P3;
    end
    f.strip_tag = host;
    f.len = host ? x.len - sfp_pkg::TAG_LEN : x.len;
    f.add_tag = c.tail_en && f.dest[2] && x.src != sfp_pkg::PORT3;
    f.tag = {7'h0, x.src == sfp_pkg::PORT2};
    f.fcs_redo = f.strip_tag || f.add_tag;
    f.drop = (f.dest == sfp_pkg::MASK_NONE);
    return f;
  endfunction : exp_fwd

  // decisions are compared in the cycle the host accepts them
  always @(posedge clk) begin
    if (!rst && out_valid === 1'b1 && out_ready === 1'b1) begin
      if (exp_q.size() == 0) begin
        chk("unexpected decision", 32'h0, 32'h1);
      end else begin
        // tail tag handling and destination choice
        chk("dest", exp_q[0].dest, out_fwd.dest);
        chk("drop", exp_q[0].drop, out_fwd.drop);
        chk("trap", exp_q[0].trap, out_fwd.trap);
        chk("strip", exp_q[0].strip_tag, out_fwd.strip_tag);
        chk("add", exp_q[0].add_tag, out_fwd.add_tag);
        chk("len", exp_q[0].len, out_fwd.len);
        chk("prio", exp_q[0].prio, out_fwd.prio);
        chk("mirror", exp_q[0].mirror, out_fwd.mirror);
        chk("fcs_redo", exp_q[0].fcs_redo, out_fwd.fcs_redo);
        chk("src", exp_q[0].src, out_fwd.src);
        if (exp_q[0].add_tag) chk("tag", exp_q[0].tag, out_fwd.tag);
        void'(exp_q.pop_front());
      end
    end
  end

  task automatic send(input sfp_pkg::sfp_desc_t x, input logic kill);
    sfp_pkg::sfp_fwd_t f;
    int k;
    f = exp_fwd(x, cfg);
    if (kill) begin
      f.dest = 3'h0;
      f.drop = 1'b1;
      f.add_tag = 1'b0;
      f.mirror = 1'b0;
      f.fcs_redo = f.strip_tag;
    end
    in_desc = x;
    in_valid = 1'b1;
    k = 0;
    while (in_ready !== 1'b1 && k < 200) begin
      @(negedge clk);
      k++;
    end
    if (k >= 200) begin
      failures++;
      finish_test();
    end
    @(posedge clk);
    exp_q.push_back(f);
    @(negedge clk);
  endtask : send

  task automatic drain();
    int k;
    in_valid = 1'b0;
    k = 0;
    while (exp_q.size() != 0 && k < 500) begin
      @(negedge clk);
      k++;
    end
    if (k >= 500) begin
      failures++;
      finish_test();
    end
  endtask : drain

  task automatic do_reset();
    rst = 1'b1;
    repeat (3) @(negedge clk);
    rst = 1'b0;
  endtask : do_reset

  function automatic sfp_pkg::sfp_desc_t rnd_desc();
    sfp_pkg::sfp_desc_t x;
    x = sfp_pkg::sfp_desc_t'(47'({$urandom, $urandom}));
    x.src = 2'($urandom % 3);
    x.ip_ver = x.ip_ver[0] ? sfp_pkg::IP_VER4 : 4'h6;
    x.ip_proto = x.ip_proto[0] ? sfp_pkg::IP_PROTO_IGMP : 8'h06;
    x.err = ($urandom % 8) == 0;
    x.len = 11'(64 + $urandom % 1455);
    return x;
  endfunction : rnd_desc

  // egress shaping: hold length for one 64-byte frame on port one queue one
  task automatic eg_case(input logic [6:0] code, input sfp_pkg::sfp_size_t md,
                         input logic sp10, input int kbps, input int bytes);
    int k;
    cfg.size_mode = md;
    cfg.speed10 = {2'h0, sp10};
    eg_rate[1] = code;
    // settings must be steady one edge before the frame is charged
    @(negedge clk);
    tx_ev = {1'b1, sfp_pkg::PORT1, 2'h1, sfp_pkg::MIN_FRAME};
    @(negedge clk);
    tx_ev = '0;
    repeat (2) @(negedge clk);
    chk("eg_hold rise", (kbps == 0) ? 0 : 1, eg_hold[1]);
    k = 0;
    while (eg_hold[1] !== 1'b0 && k < 3000) begin
      @(negedge clk);
      k++;
    end
    if (kbps != 0 && (k < bytes * 80000 / kbps - 4 ||
                      k > bytes * 80000 / kbps + 4)) begin
      chk("eg_hold cycles", bytes * 80000 / kbps, k);
    end
    chk("eg_hold fall", 0, eg_hold[1]);
  endtask : eg_case

  initial begin
    void'($urandom(47));
    do_reset();
    busy = 8'd30;
    // every host destination and priority code, then tagging off
    cfg.tail_en = 1'b1;
    for (int i = 0; i < 32; i++) begin
      d = rnd_desc();
      d.src = sfp_pkg::PORT3;
      d.err = 1'b0;
      d.tag = {4'h0, 4'(i)};
      if (i >= 16) cfg.tail_en = 1'b0;
      send(d, 1'b0);
    end
    drain();
    // igmp via ethernet and snap, snooping on, plus a v6 frame
    cfg = '0;
    // host enables snooping, tagging and reporting
    cfg.snoop_en = 1'b1;
    cfg.tail_en = 1'b1;
    cfg.tail_rep = 1'b1;
    for (int i = 0; i < 3; i++) begin
      d = '0;
      d.src = sfp_pkg::PORT2;
      d.lookup = 3'h1;
      d.ip_eth = (i != 1);
      d.ip_snap = (i == 1);
      d.ip_ver = (i == 2) ? 4'h6 : sfp_pkg::IP_VER4;
      d.ip_proto = sfp_pkg::IP_PROTO_IGMP;
      d.len = sfp_pkg::MIN_FRAME;
      send(d, 1'b0);
    end
    drain();
    // random traffic under random settings, ingress unlimited
    for (int b = 0; b < 12; b++) begin
      cfg = sfp_pkg::sfp_cfg_t'(26'($urandom));
      cfg.ig_class = sfp_pkg::SFP_CLS_ALL;
      cfg.size_mode = sfp_pkg::SFP_SZ_DATA;
      for (int i = 0; i < 25; i++) send(rnd_desc(), 1'b0);
      drain();
    end
    // stalled host: exactly two decisions are buffered
    busy = 8'd100;
    repeat (2) @(negedge clk);
    d = rnd_desc();
    in_desc = d;
    in_valid = 1'b1;
    n = 0;
    repeat (6) begin
      if (in_ready === 1'b1) begin
        exp_q.push_back(exp_fwd(d, cfg));
        n++;
      end
      @(negedge clk);
    end
    chk("buffered words", 2, n);
    in_valid = 1'b0;
    busy = 8'd0;
    drain();
    // egress shaping for each size mode, and a 10 mbps unlimited case
    cfg = '0;
    eg_case(7'd100, sfp_pkg::SFP_SZ_DATA, 1'b0, 85000, 64);
    eg_case(7'd100, sfp_pkg::SFP_SZ_IFG, 1'b0, 85000, 76);
    eg_case(7'd100, sfp_pkg::SFP_SZ_PRE, 1'b0, 85000, 72);
    eg_case(7'd100, sfp_pkg::SFP_SZ_DATA, 1'b1, 0, 64);
    // exhausted memory leads to pause or drop
    for (int i = 0; i < 16; i++) begin
      cfg.fc_mode = i[0];
      mem_full = 3'($urandom);
      @(negedge clk);
      chk("fc_req", cfg.fc_mode ? mem_full : 3'h0, fc_req);
      chk("mem_drop", cfg.fc_mode ? 3'h0 : mem_full, mem_drop);
    end
    mem_full = 3'h0;
    // ingress limit at 64 kbps on port one priority zero
    do_reset();
    ig_rate[0] = 7'd1;
    d = '0;
    d.src = sfp_pkg::PORT1;
    d.static_hit = 1'b1;
    d.lookup = 3'h2;
    d.len = sfp_pkg::MAX_FRAME;
    send(d, 1'b0);
    send(d, 1'b0);
    send(d, 1'b1);
    drain();
    cfg.ig_class = sfp_pkg::SFP_CLS_BC;
    send(d, 1'b0);
    drain();
    finish_test();
  end
endmodule : tb
